// ---- shared/frews_pkg.sv ----
/*
  Shared constants of the row erase/write sequencer: register selects,
  control bit positions, unlock keys, latch geometry and operation timing.
  Assumes a 20 MHz system clock.
*/
`default_nettype none
package frews_pkg;
  // Register selects on the core bus
  localparam logic [2:0] REG_ADDR_LOW   = 3'h0;
  localparam logic [2:0] REG_ADDR_HIGH  = 3'h1;
  localparam logic [2:0] REG_WORD_LOW   = 3'h2;
  localparam logic [2:0] REG_WORD_HIGH  = 3'h3;
  localparam logic [2:0] REG_CONTROL    = 3'h4;
  localparam logic [2:0] REG_UNLOCK_KEY = 3'h5;
  // nvm_control bit positions
  localparam int CTL_FETCH_GO    = 0;
  localparam int CTL_GO          = 1;
  localparam int CTL_ENABLE      = 2;
  localparam int CTL_FAULT       = 3;
  localparam int CTL_ERASE       = 4;
  localparam int CTL_LATCH_ONLY  = 5;
  localparam int CTL_CFG_SPACE   = 6;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Latch geometry
  localparam int NUM_LATCHES = 16;
  localparam int IDX_W       = 4;
  localparam int WORD_W      = 14;
  localparam int ROW_W       = 10;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;
  // Self-timed erase/write
  localparam int CLK_KHZ    = 20000;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES  = OP_TIME_US * CLK_KHZ / 1000;
  localparam int TIMER_W    = 16;
  // Controller AXI4-Lite map
  localparam logic [3:0] AXI_XFER   = 4'h0;
  localparam logic [3:0] AXI_SEQ    = 4'h4;
  localparam logic [3:0] AXI_STATUS = 4'h8;
  localparam int XFER_SEL_LSB = 8;
  localparam int XFER_READ    = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- shared/frews_bus_if.sv ----
/*
  Core bus between the processor-side controller and the sequencer.
  Assumes both ends run on aclk; reg_wr and reg_rd are one-cycle strobes.
*/
`default_nettype none
interface frews_bus_if;
  logic       reg_wr;
  logic       reg_rd;
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       core_hold;

  modport device (
    input  reg_wr,
    input  reg_rd,
    input  reg_sel,
    input  reg_wdata,
    output reg_rdata,
    output core_hold
  );

  modport core (
    output reg_wr,
    output reg_rd,
    output reg_sel,
    output reg_wdata,
    input  reg_rdata,
    input  core_hold
  );
endinterface
`default_nettype wire

// ---- design/frews_latches.sv ----
/*
  Bank of row write latches, one flop word per entry.
  Assumes load and preset never come in the same cycle.
*/
`default_nettype none
module frews_latches
(
  // Clock and reset
  input  wire logic                                               aclk,
  input  wire logic                                               aresetn,
  // Control
  input  wire logic                                               load,
  input  wire logic                                               preset,
  input  wire logic [frews_pkg::IDX_W-1:0]                        index,
  input  wire logic [frews_pkg::WORD_W-1:0]                       data,
  // Contents
  output logic      [frews_pkg::NUM_LATCHES*frews_pkg::WORD_W-1:0] image
);
  import frews_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NUM_LATCHES; g++)
    begin : g_latch
      always_ff @(posedge aclk)
      begin
        if (!aresetn || preset)
          image[g*WORD_W +: WORD_W] <= BLANK_WORD;
        else if (load && index == IDX_W'(g))
          image[g*WORD_W +: WORD_W] <= data;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- design/frews_device.sv ----
/*
  Flash row erase/write sequencer, device end. Holds the address, data and
  control registers, checks the unlock sequence, loads the row latches and
  times erase and row programming while holding the core.
  Assumes the core obeys core_hold and drives one access per cycle at most.
*/
// Notes on behaviour
// - Erase works on whole rows only
// - Software: address, flags, 55h, AAh, go
// - Two slots after go act as no-ops
// - Core held during self-timed erase
// - Core resumes at third slot after go
// - Writing never erases first
// - One write covers one to sixteen words
// - Row from upper ten bits, latch low
// - Programming stays inside the addressed row
// - Latches preset blank after each operation
// - Latch-only mode just loads the latch
// - Otherwise load latch then program row
// - Broken unlock loads and programs nothing
// - Software loads latches then final programming unlock
// - Unloaded latches stay blank
// - Core held during self-timed row write
// - Software keeps row copy for partial change
// - Go bits set by software, cleared here
// - Operations need enable; enable clear at power-up
// - Reset during operation raises fault flag
`default_nettype none
module frews_device
#(
  parameter int unsigned OP_CYCLES = frews_pkg::OP_CYCLES
)
(
  // Clock and resets
  input  wire logic                                               aclk,
  input  wire logic                                               aresetn,
  input  wire logic                                               por_n,
  // Core bus
  frews_bus_if.device                                             bus,
  // Flash array
  output logic                                                    flash_erase,
  output logic                                                    flash_program,
  output logic      [frews_pkg::ROW_W-1:0]                        flash_row,
  output logic      [frews_pkg::NUM_LATCHES*frews_pkg::WORD_W-1:0] flash_image
);
  import frews_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PREP1, ST_PREP2, ST_OP} frews_state_e;
  typedef enum logic [1:0] {UK_IDLE, UK_ONE, UK_TWO} frews_unlock_e;

  frews_state_e        state;
  frews_state_e        next_state;
  frews_unlock_e       unlock;
  logic                rst;
  logic                acc_wr;
  logic                acc_rd;
  logic                ctl_wr;
  logic                go_attempt;
  logic                launch;
  logic                op_done;
  logic                op_erase;
  logic                op_write;
  logic [7:0]          addr_low;
  logic [6:0]          addr_high;
  logic [7:0]          word_low;
  logic [5:0]          word_high;
  logic                cfg_space;
  logic                latch_only;
  logic                erase_sel;
  logic                fault;
  logic                enable;
  logic                go;
  logic                fetch_go;
  logic [TIMER_W-1:0]  timer;
  logic [7:0]          control;

  assign rst = !aresetn || !por_n;
  // Accesses in the two slots after go, and during the stall, are dropped
  assign acc_wr = bus.reg_wr && state == ST_IDLE;
  assign acc_rd = bus.reg_rd && state == ST_IDLE;
  assign ctl_wr = acc_wr && bus.reg_sel == REG_CONTROL;
  assign go_attempt = ctl_wr && bus.reg_wdata[CTL_GO] && unlock == UK_TWO;
  // Enable and memory space are taken from the byte that sets go
  assign launch = go_attempt && bus.reg_wdata[CTL_ENABLE]
                  && !bus.reg_wdata[CTL_CFG_SPACE];
  assign op_done = state == ST_OP && timer == TIMER_W'(OP_CYCLES - 1);
  assign control = {1'b1, cfg_space, latch_only, erase_sel, fault, enable, go, fetch_go};

  // Unlock detector: any other access between the steps starts over
  always_ff @(posedge aclk)
  begin
    if (rst)
      unlock <= UK_IDLE;
    else if (acc_wr || acc_rd)
    begin
      if (acc_wr && bus.reg_sel == REG_UNLOCK_KEY && bus.reg_wdata == KEY_FIRST)
        unlock <= UK_ONE;
      else if (unlock == UK_ONE && acc_wr && bus.reg_sel == REG_UNLOCK_KEY
               && bus.reg_wdata == KEY_SECOND)
        unlock <= UK_TWO;
      else
        unlock <= UK_IDLE;
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (launch)
          next_state = ST_PREP1;
      ST_PREP1:
        next_state = ST_PREP2;
      ST_PREP2:
        // Latch-only loads return to the core after the two slots
        next_state = (op_erase || op_write) ? ST_OP : ST_IDLE;
      ST_OP:
        if (op_done)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Hold covers the two forced slots and the self-timed operation
  always_ff @(posedge aclk)
  begin
    if (rst)
      bus.core_hold <= 1'b0;
    else
      bus.core_hold <= next_state != ST_IDLE;
  end

  // Operation kind and row are frozen at launch
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      op_erase  <= 1'b0;
      op_write  <= 1'b0;
      flash_row <= '0;
    end
    else if (launch)
    begin
      op_erase  <= bus.reg_wdata[CTL_ERASE];
      // A write is never turned into an erase
      op_write  <= !bus.reg_wdata[CTL_ERASE] && !bus.reg_wdata[CTL_LATCH_ONLY];
      flash_row <= {addr_high, addr_low[7:5]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      flash_erase   <= 1'b0;
      flash_program <= 1'b0;
    end
    else
    begin
      flash_erase   <= next_state == ST_OP && op_erase;
      flash_program <= next_state == ST_OP && op_write;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst || state != ST_OP)
      timer <= '0;
    else
      timer <= timer + TIMER_W'(1);
  end

  // Address and data registers
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      addr_low  <= '0;
      addr_high <= '0;
      word_low  <= '0;
      word_high <= '0;
    end
    else if (acc_wr)
    begin
      unique case (bus.reg_sel)
        REG_ADDR_LOW:  addr_low  <= bus.reg_wdata;
        REG_ADDR_HIGH: addr_high <= bus.reg_wdata[6:0];
        REG_WORD_LOW:  word_low  <= bus.reg_wdata;
        REG_WORD_HIGH: word_high <= bus.reg_wdata[5:0];
        default:       ;
      endcase
    end
  end

  // Plain control fields; enable is clear after power-up
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      cfg_space  <= 1'b0;
      latch_only <= 1'b0;
      enable     <= 1'b0;
    end
    else if (ctl_wr)
    begin
      cfg_space  <= bus.reg_wdata[CTL_CFG_SPACE];
      latch_only <= bus.reg_wdata[CTL_LATCH_ONLY];
      enable     <= bus.reg_wdata[CTL_ENABLE];
    end
  end

  // Erase select clears itself when the erase ends
  always_ff @(posedge aclk)
  begin
    if (rst)
      erase_sel <= 1'b0;
    else if (op_done && op_erase)
      erase_sel <= 1'b0;
    else if (ctl_wr)
      erase_sel <= bus.reg_wdata[CTL_ERASE];
  end

  // Go bits: software may only set them
  always_ff @(posedge aclk)
  begin
    if (rst)
      go <= 1'b0;
    else if (launch)
      go <= 1'b1;
    else if (op_done || (state == ST_PREP2 && next_state == ST_IDLE))
      go <= 1'b0;
  end

  // Program memory reads are not built, so a fetch completes at once
  always_ff @(posedge aclk)
  begin
    if (rst)
      fetch_go <= 1'b0;
    else
      fetch_go <= ctl_wr && bus.reg_wdata[CTL_FETCH_GO];
  end

  // Survives the ordinary reset; power-up or a control write with the bit clear clears it
  always_ff @(posedge aclk)
  begin
    if (!por_n)
      fault <= 1'b0;
    else if (!aresetn)
    begin
      if (state != ST_IDLE && (op_erase || op_write))
        fault <= 1'b1;
    end
    else if (ctl_wr)
      fault <= bus.reg_wdata[CTL_FAULT];
  end

  always_ff @(posedge aclk)
  begin
    if (rst)
      bus.reg_rdata <= '0;
    else if (acc_rd)
    begin
      unique case (bus.reg_sel)
        REG_ADDR_LOW:  bus.reg_rdata <= addr_low;
        REG_ADDR_HIGH: bus.reg_rdata <= {1'b1, addr_high};
        REG_WORD_LOW:  bus.reg_rdata <= word_low;
        REG_WORD_HIGH: bus.reg_rdata <= {2'b00, word_high};
        REG_CONTROL:   bus.reg_rdata <= control;
        default:       bus.reg_rdata <= '0;
      endcase
    end
  end

  // Latches beyond the sixteenth slot of a row are not loaded
  frews_latches u_latches
  (
    .aclk    (aclk),
    .aresetn (!rst),
    .load    (launch && !bus.reg_wdata[CTL_ERASE] && !addr_low[IDX_W]),
    .preset  (op_done),
    .index   (addr_low[IDX_W-1:0]),
    .data    ({word_high, word_low}),
    .image   (flash_image)
  );
endmodule
`default_nettype wire

// ---- design/frews_core.sv ----
/*
  Core-side controller: an AXI4-Lite slave whose registers let software issue
  single accesses to the sequencer or a whole unlock-and-go sequence.
  Assumes the sequencer answers reads on the cycle after the strobe.
*/
`default_nettype none
module frews_core
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Sequencer bus
  frews_bus_if.core        bus
);
  import frews_pkg::*;

  logic [3:0]  aw_addr;
  logic        aw_got;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_got;
  logic        wr_fire;
  logic        busy;
  logic        cmd_xfer;
  logic        cmd_seq;
  logic        pending;
  logic        p_read;
  logic [2:0]  p_sel;
  logic [7:0]  p_data;
  logic [1:0]  seq_step;
  logic [7:0]  seq_ctl;
  logic        rd_wait;
  logic [7:0]  last_rdata;
  logic        can_issue;

  assign wr_fire  = aw_got && w_got && !bvalid;
  assign busy     = pending || seq_step != 2'd0 || bus.reg_rd || rd_wait;
  assign cmd_xfer = wr_fire && {aw_addr[3:2], 2'b00} == AXI_XFER && w_strb[0] && !busy;
  assign cmd_seq  = wr_fire && {aw_addr[3:2], 2'b00} == AXI_SEQ && w_strb[0] && !busy;
  // One idle slot after a single write strobe, two after a read, so the hold is seen before the next
  assign can_issue = !bus.core_hold && !bus.reg_wr && !bus.reg_rd && !rd_wait;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      aw_got  <= 1'b0;
      aw_addr <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_addr <= awaddr;
      aw_got  <= 1'b1;
      awready <= 1'b0;
    end
    else if (wr_fire)
      aw_got <= 1'b0;
    else if (!aw_got && !bvalid)
      awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b0;
      w_got  <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (wvalid && wready)
    begin
      w_data <= wdata;
      w_strb <= wstrb;
      w_got  <= 1'b1;
      wready <= 1'b0;
    end
    else if (wr_fire)
      w_got <= 1'b0;
    else if (!w_got && !bvalid)
      wready <= 1'b1;
  end

  // Refused commands answer SLVERR so software sees they were dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp  <= (cmd_xfer || cmd_seq || {aw_addr[3:2], 2'b00} == AXI_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      unique case ({araddr[3:2], 2'b00})
        AXI_STATUS: rdata <= {16'h0000, last_rdata, 6'h00, bus.core_hold, busy};
        AXI_XFER:   rdata <= {15'h0000, p_read, 5'h00, p_sel, p_data};
        AXI_SEQ:    rdata <= {24'h000000, seq_ctl};
        default:    rresp <= RESP_SLVERR;
      endcase
    end
    else if (rvalid)
    begin
      if (rready)
        rvalid <= 1'b0;
    end
    else
      arready <= 1'b1;
  end

  // The sequence runs as three back-to-back writes nothing can split
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pending       <= 1'b0;
      p_read        <= 1'b0;
      p_sel         <= '0;
      p_data        <= '0;
      seq_step      <= 2'd0;
      seq_ctl       <= '0;
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_sel   <= '0;
      bus.reg_wdata <= '0;
    end
    else
    begin
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      if (cmd_xfer)
      begin
        pending <= 1'b1;
        p_read  <= w_data[XFER_READ];
        p_sel   <= w_data[XFER_SEL_LSB +: 3];
        p_data  <= w_data[7:0];
      end
      else if (cmd_seq)
      begin
        seq_step <= 2'd1;
        seq_ctl  <= w_data[7:0];
      end
      else if (seq_step != 2'd0 && !bus.core_hold)
      begin
        bus.reg_wr <= 1'b1;
        unique case (seq_step)
          2'd1:
          begin
            bus.reg_sel   <= REG_UNLOCK_KEY;
            bus.reg_wdata <= KEY_FIRST;
          end
          2'd2:
          begin
            bus.reg_sel   <= REG_UNLOCK_KEY;
            bus.reg_wdata <= KEY_SECOND;
          end
          default:
          begin
            bus.reg_sel   <= REG_CONTROL;
            bus.reg_wdata <= seq_ctl | 8'h02;
          end
        endcase
        seq_step <= (seq_step == 2'd3) ? 2'd0 : seq_step + 2'd1;
      end
      else if (pending && can_issue)
      begin
        pending       <= 1'b0;
        bus.reg_wr    <= !p_read;
        bus.reg_rd    <= p_read;
        bus.reg_sel   <= p_sel;
        bus.reg_wdata <= p_data;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_wait    <= 1'b0;
      last_rdata <= '0;
    end
    else
    begin
      rd_wait <= bus.reg_rd;
      if (rd_wait)
        last_rdata <= bus.reg_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- tb/frews_assertions.sv ----
/*
  Concurrent checks on core bus and flash strobes.
  Assumes one clock aclk, sync active-low aresetn.
*/
`default_nettype none
module frews_assertions
  import frews_pkg::*;
#(
  parameter int unsigned OP_CYCLES = 20
)
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Core bus
  input wire logic       reg_wr,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic       core_hold,
  // Flash array
  input wire logic       flash_erase,
  input wire logic       flash_program
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic        op;
  logic        key1;
  logic        key2;
  logic        go;
  logic        ok_go;
  logic        bad_go;
  logic        lo;
  logic        er;
  logic [15:0] run_len;

  assign op     = flash_erase || flash_program;
  assign key1   = reg_wr && reg_sel == REG_UNLOCK_KEY && reg_wdata == KEY_FIRST;
  assign key2   = reg_wr && reg_sel == REG_UNLOCK_KEY && reg_wdata == KEY_SECOND;
  assign go     = reg_wr && reg_sel == REG_CONTROL && reg_wdata[CTL_GO];
  assign ok_go  = go && !core_hold && reg_wdata[CTL_ENABLE] && !reg_wdata[CTL_CFG_SPACE];
  assign bad_go = go && !core_hold && !ok_go;
  assign lo     = reg_wdata[CTL_LATCH_ONLY];
  assign er     = reg_wdata[CTL_ERASE];

  // Too long for a repetition
  always_ff @(posedge aclk)
    if (!aresetn || !op)
      run_len <= '0;
    else
      run_len <= run_len + 16'h1;

  sequence s_keys;
    key1 ##1 key2;
  endsequence

  property p_go_hold;
    s_keys ##1 ok_go |=> core_hold;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("no hold after go");
  property p_bad_go;
    s_keys ##1 bad_go |=> !core_hold;
  endproperty
  a_bad_go: assert property (p_bad_go) else $error("go ran, no enable");
  property p_no_key;
    go && !core_hold && !$past(key2) |=> !core_hold;
  endproperty
  a_no_key: assert property (p_no_key) else $error("go ran, no keys");
  property p_latch_only;
    s_keys ##1 (ok_go && lo && !er) |=> (core_hold && !flash_program) [*2] ##1 (!core_hold && !flash_program);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("bad latch load");
  property p_program;
    s_keys ##1 (ok_go && !lo && !er) |-> ##3 (flash_program && !flash_erase);
  endproperty
  a_program: assert property (p_program) else $error("no row write");
  property p_erase;
    s_keys ##1 (ok_go && er) |-> ##3 (flash_erase && !flash_program);
  endproperty
  a_erase: assert property (p_erase) else $error("no row erase");
  property p_prep;
    $rose(op) |-> $past(core_hold, 2) && !$past(core_hold, 3);
  endproperty
  a_prep: assert property (p_prep) else $error("prep slots not two");
  property p_len;
    $fell(op) |-> run_len == 16'(OP_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("bad run length");
  property p_release;
    $fell(op) |-> $fell(core_hold);
  endproperty
  a_release: assert property (p_release) else $error("no release at end");
  property p_held;
    op |-> core_hold;
  endproperty
  a_held: assert property (p_held) else $error("core runs in op");
  property p_exclusive;
    !(flash_erase && flash_program);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("erase during write");
endmodule
`default_nettype wire

// ---- tb/frews_tb_top.sv ----
/*
  Bench: controller and device joined by the core bus.
  Assumes nothing else drives AXI; latches modelled as ints.
*/
`default_nettype none
module frews_tb_top
  import frews_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OP_LEN = 20;
  localparam int IMG_W  = NUM_LATCHES * WORD_W;
  logic             aclk    = 1'b0;
  logic             aresetn = 1'b0;
  logic             por_n   = 1'b0;
  logic [3:0]       awaddr  = 4'h0;
  logic [3:0]       araddr  = 4'h0;
  logic [3:0]       wstrb   = 4'h0;
  logic [31:0]      wdata   = 32'h0;
  logic             awvalid = 1'b0;
  logic             wvalid  = 1'b0;
  logic             bready  = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready  = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, r;
  logic [31:0]      rdata, st;
  logic             flash_erase, flash_program;
  logic [ROW_W-1:0] flash_row;
  logic [IMG_W-1:0] flash_image;
  logic [7:0]       ah, al;
  int               err_count  = 0;
  int               num_checks = 0;
  int               seed       = 63;
  int               lat[NUM_LATCHES];
  logic [IMG_W-1:0] img_q[$];
  logic [ROW_W-1:0] row_q[$];
  logic [ROW_W-1:0] er_q[$];

  always #25 aclk = ~aclk;
  frews_bus_if bus ();
  frews_core i_frews_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(bus.core));
  frews_device #(.OP_CYCLES(OP_LEN)) i_frews_device (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .bus(bus.device), .flash_erase(flash_erase), .flash_program(flash_program), .flash_row(flash_row),
    .flash_image(flash_image));
  frews_assertions #(.OP_CYCLES(OP_LEN)) i_frews_assertions (.aclk(aclk), .aresetn(aresetn),
    .reg_wr(bus.reg_wr), .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata), .core_hold(bus.core_hold),
    .flash_erase(flash_erase), .flash_program(flash_program));

  // Snapshot as each run starts
  always @(posedge aclk)
  begin
    if ($rose(flash_program))
    begin
      img_q.push_back(flash_image);
      row_q.push_back(flash_row);
    end
    if ($rose(flash_erase))
      er_q.push_back(flash_row);
  end

  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_free();
    do axi_rd(AXI_STATUS, st); while (st[1:0] != 2'h0);
  endtask
  task automatic dev_wr(input logic [2:0] sel, logic [7:0] v);
    axi_wr(AXI_XFER, {21'h0, sel, v}, 4'hf);
    wait_free();
  endtask
  task automatic dev_rd(input logic [2:0] sel, output logic [7:0] v);
    axi_wr(AXI_XFER, {15'h0, 1'b1, 5'h0, sel, 8'h0}, 4'hf);
    wait_free();
    axi_rd(AXI_STATUS, st);
    v = st[15:8];
  endtask
  task automatic go_seq(input logic [7:0] ctl);
    axi_wr(AXI_SEQ, {24'h0, ctl}, 4'hf);
    wait_free();
  endtask
  task automatic load(input logic x4, logic [3:0] i, logic [13:0] w, logic [7:0] ctl);
    dev_wr(REG_ADDR_LOW, {al[7:5], x4, i});
    dev_wr(REG_WORD_LOW, w[7:0]);
    dev_wr(REG_WORD_HIGH, {2'h0, w[13:8]});
    go_seq(ctl);
    if (!x4)
      lat[i] = w;
  endtask
  task automatic chk_img(input logic [IMG_W-1:0] im);
    for (int i = 0; i < NUM_LATCHES; i++)
      chk(im[i*WORD_W +: WORD_W], lat[i]);
  endtask
  task automatic blank();
    foreach (lat[i])
      lat[i] = 32'h3fff;
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    logic [7:0]  b;
    logic [31:0] d;
    int          n;
    blank();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_img(flash_image);
    dev_rd(REG_CONTROL, b);
    chk(b, 8'h80);
    dev_rd(REG_UNLOCK_KEY, b);
    chk(b, 8'h00);
    end_test("reset");
    d = $random(seed);
    ah = {1'b0, d[6:0]};
    al = d[15:8];
    dev_wr(REG_ADDR_HIGH, ah);
    dev_wr(REG_ADDR_LOW, al);
    go_seq(8'h14);
    chk(er_q.size(), 1);
    chk(er_q.pop_front(), {ah[6:0], al[7:5]});
    dev_rd(REG_CONTROL, b);
    chk(b, 8'h84);
    end_test("erase");
    d = $random(seed);
    al = {al[7:5], 5'h0};
    n = d[19:16];
    dev_wr(REG_ADDR_HIGH, ah);
    for (int k = 0; k <= n; k++)
    begin
      d = $random(seed);
      load(1'b0, d[3:0], d[29:16], 8'h24);
    end
    load(1'b1, d[7:4], ~d[29:16], 8'h24);
    chk_img(flash_image);
    chk(img_q.size(), 0);
    d = $random(seed);
    load(1'b0, d[3:0], d[29:16], 8'h04);
    chk(img_q.size(), 1);
    chk_img(img_q.pop_front());
    chk(row_q.pop_front(), {ah[6:0], al[7:5]});
    blank();
    chk_img(flash_image);
    end_test("program");
    dev_wr(REG_UNLOCK_KEY, KEY_FIRST);
    dev_wr(REG_UNLOCK_KEY, KEY_SECOND);
    dev_rd(REG_WORD_LOW, b);
    dev_wr(REG_CONTROL, 8'h26);
    chk_img(flash_image);
    dev_rd(REG_CONTROL, b);
    chk(b, 8'ha4);
    for (int i = 0; i < 2; i++)
    begin
      go_seq(i ? 8'h54 : 8'h10);
      chk(er_q.size(), 0);
    end
    end_test("refused");
    axi_wr(AXI_SEQ, 32'h14, 4'hf);
    while (flash_erase !== 1'b1)
      @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    er_q.delete();
    dev_rd(REG_CONTROL, b);
    chk(b[CTL_FAULT], 1'b1);
    @(posedge aclk);
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    repeat (2) @(posedge aclk);
    dev_rd(REG_CONTROL, b);
    chk(b, 8'h80);
    end_test("fault");
    axi_wr(4'hc, 32'h0, 4'hf);
    chk(r, RESP_SLVERR);
    axi_rd(4'hc, d);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(AXI_XFER, 32'h0, 4'h0);
    chk(r, RESP_SLVERR);
    axi_wr(AXI_STATUS, 32'h0, 4'hf);
    chk(r, RESP_OKAY);
    end_test("axi");
    give_verdict();
  end

  // Hang guard, well past the test length
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
